// >>> include/ais_pkg.sv
/*
 * Shared constants and types for the analog input scaling block:
 * register offsets, reset values, limits, timing and state types.
 * Assumes a single 20 MHz clock domain and APB register access.
 */
`default_nettype none

package ais_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [11:0] AIS_OFF_CTRL = 12'h000;
    localparam logic [11:0] AIS_OFF_VMIN = 12'h004;
    localparam logic [11:0] AIS_OFF_VMAX = 12'h008;
    localparam logic [11:0] AIS_OFF_CMIN = 12'h00c;
    localparam logic [11:0] AIS_OFF_CMAX = 12'h010;
    localparam logic [11:0] AIS_OFF_FILT = 12'h014;
    localparam logic [11:0] AIS_OFF_XPT = 12'h018;
    localparam logic [11:0] AIS_OFF_YPT = 12'h01c;
    localparam logic [11:0] AIS_OFF_ASSIGN = 12'h020;
    localparam logic [11:0] AIS_OFF_STATUS = 12'h024;
    localparam logic [11:0] AIS_OFF_REF = 12'h028;
    localparam logic [11:0] AIS_OFF_FILTD = 12'h02c;
    // field positions
    localparam int AIS_BIT_TYPE = 0;
    localparam int AIS_BIT_RANGE = 1;
    localparam int AIS_BIT_NONE = 16;
    localparam int AIS_BIT_BIPOLAR = 0;
    localparam int AIS_BIT_BUSY = 1;
    // ---------------------------------------------------------------
    // reset values and limits (0.1 V, 0.1 mA, 10 ms, 1 %)
    // ---------------------------------------------------------------
    localparam logic [6:0] AIS_RST_VMIN = 7'h00;
    localparam logic [6:0] AIS_RST_VMAX = 7'h64;
    localparam logic [7:0] AIS_RST_CMIN = 8'h00;
    localparam logic [7:0] AIS_RST_CMAX = 8'hc8;
    localparam logic [9:0] AIS_RST_FILT = 10'h000;
    localparam logic [6:0] AIS_RST_XPT = 7'h00;
    localparam logic [6:0] AIS_RST_YPT = 7'h00;
    localparam logic [15:0] AIS_LIM_V = 16'h0064;
    localparam logic [15:0] AIS_LIM_C = 16'h00c8;
    localparam logic [15:0] AIS_LIM_F = 16'h03e8;
    localparam logic [15:0] AIS_LIM_P = 16'h0064;
    localparam logic [7:0] AIS_CMIN_BI = 8'h1e;
    // one config unit in sample units (mV or uA), one % in 0.01 %
    localparam logic [15:0] AIS_UNIT = 16'h0064;
    localparam logic [15:0] AIS_FULL = 16'h2710;
    localparam logic [13:0] AIS_FILT_MS = 14'h000a;
    localparam logic [31:0] AIS_RECIP_ONE = 32'h0100_0000;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int AIS_CLK_MHZ = 20;
    localparam int AIS_TICK_US = 1000;
    localparam int AIS_TICK_CYC = AIS_TICK_US * AIS_CLK_MHZ;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        AIS_ST_IDLE = 3'b000,
        AIS_ST_RECIP = 3'b001,
        AIS_ST_PREP = 3'b010,
        AIS_ST_POS = 3'b011,
        AIS_ST_SEGP = 3'b100,
        AIS_ST_SEG = 3'b101
    } ais_fsm_type;

    typedef struct packed {
        logic type_cur;
        logic range_bi;
        logic [6:0] vmin;
        logic [6:0] vmax;
        logic [7:0] cmin;
        logic [7:0] cmax;
        logic [9:0] filt;
        logic [6:0] xpt;
        logic [6:0] ypt;
    } ais_cfg_type;

    typedef struct packed {
        ais_cfg_type cfg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] tick_cnt;
        logic tick_pend;
        logic recip_pend;
        logic [15:0] sample;
        logic [24:0] k;
        logic [39:0] acc;
        ais_fsm_type fsm;
        logic [31:0] dv_num;
        logic [15:0] dv_den;
        logic [15:0] dv_rem;
        logic [5:0] dv_cnt;
        logic [15:0] pos;
        logic [15:0] base;
        logic [15:0] refv;
        logic ref_valid;
        logic bipolar;
    } ais_state_type;
endpackage

`default_nettype wire

// >>> hw/ais_scaler.sv
/*
 * First analog input conditioning: type select, min/max scaling,
 * first-order low-pass filter, two-segment curve and range mapping,
 * with an APB register slave.
 * Assumes samples arrive from logic on i_clk in mV or uA.
 */
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: voltage or current type, voltage default
// RULE_02: voltage min is 0 % point
// RULE_03: voltage max is 100 % point
// RULE_04: current min is 0 % point
// RULE_05: current max is 100 % point
// RULE_06: low-pass cutoff up to ten seconds
// RULE_07: X point as percent of span
// RULE_08: at X output equals Y percent
// RULE_09: read-only assignment with none indication
// RULE_10: force unidirectional unless current and min>=3mA
// RULE_11: unidirectional maps min..max to 0..100 %
// RULE_12: bidirectional maps min..max to -100..100 %
// RULE_13: two-segment interpolation, clamped to span
// RULE_14: first-order filter, bypass at zero
module ais_scaler #(
    parameter int P_TICK_CYCLES = ais_pkg::AIS_TICK_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // converted sample and drive context
    input wire logic [15:0] i_sample,
    input wire logic i_sample_valid,
    input wire logic [15:0] i_assigned_functions,
    // frequency reference out
    output logic [15:0] o_reference,
    output logic o_reference_valid,
    output logic o_bipolar_range_code
);
    generate
        if (P_TICK_CYCLES < 1) begin : g_bad
            $error("P_TICK_CYCLES must be at least 1");
        end
    endgenerate

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] sat(input logic [31:0] v,
                                        input logic [15:0] lim);
        sat = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    function automatic logic [15:0] scale(input logic [15:0] v,
                                          input logic [15:0] u);
        logic [31:0] p;
        p = v * u;
        scale = p[15:0];
    endfunction

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ais_pkg::ais_state_type s_q;
    ais_pkg::ais_state_type s_d;

    logic apb_acc;
    logic bi_eff;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] y;
    logic [15:0] xi;
    logic [15:0] yi;
    logic [16:0] dstep;
    logic [16:0] fdiff;
    logic [42:0] fprod;

    always_comb begin
        s_d = s_q;
        s_d.ref_valid = 1'b0;
        apb_acc = i_psel & i_penable;
        // RULE_10: forced unidirectional
        bi_eff = s_q.cfg.type_cur & s_q.cfg.range_bi &
                 (s_q.cfg.cmin >= ais_pkg::AIS_CMIN_BI);
        s_d.bipolar = bi_eff;
        // RULE_02: RULE_03: RULE_04: RULE_05: active points
        if (s_q.cfg.type_cur) begin
            lo = scale({8'h00, s_q.cfg.cmin}, ais_pkg::AIS_UNIT);
            hi = scale({8'h00, s_q.cfg.cmax}, ais_pkg::AIS_UNIT);
        end else begin
            lo = scale({9'h000, s_q.cfg.vmin}, ais_pkg::AIS_UNIT);
            hi = scale({9'h000, s_q.cfg.vmax}, ais_pkg::AIS_UNIT);
        end
        y = s_q.acc[39:24];
        xi = scale({9'h000, s_q.cfg.xpt}, ais_pkg::AIS_UNIT);
        yi = scale({9'h000, s_q.cfg.ypt}, ais_pkg::AIS_UNIT);
        dstep = {s_q.dv_rem, s_q.dv_num[31]};
        fdiff = {1'b0, s_q.sample} - {1'b0, y};
        fprod = 43'(signed'(fdiff) * signed'({1'b0, s_q.k}));

        // -----------------------------------------------------------
        // apb: one wait state, write lands with pready
        // -----------------------------------------------------------
        s_d.pready = apb_acc & ~s_q.pready;
        if (apb_acc & ~s_q.pready) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h0000_0000;
            case (i_paddr)
                ais_pkg::AIS_OFF_CTRL: begin
                    s_d.prdata[ais_pkg::AIS_BIT_TYPE] = s_q.cfg.type_cur;
                    s_d.prdata[ais_pkg::AIS_BIT_RANGE] = s_q.cfg.range_bi;
                end
                ais_pkg::AIS_OFF_VMIN: s_d.prdata[6:0] = s_q.cfg.vmin;
                ais_pkg::AIS_OFF_VMAX: s_d.prdata[6:0] = s_q.cfg.vmax;
                ais_pkg::AIS_OFF_CMIN: s_d.prdata[7:0] = s_q.cfg.cmin;
                ais_pkg::AIS_OFF_CMAX: s_d.prdata[7:0] = s_q.cfg.cmax;
                ais_pkg::AIS_OFF_FILT: s_d.prdata[9:0] = s_q.cfg.filt;
                ais_pkg::AIS_OFF_XPT: s_d.prdata[6:0] = s_q.cfg.xpt;
                ais_pkg::AIS_OFF_YPT: s_d.prdata[6:0] = s_q.cfg.ypt;
                // RULE_09: assignment read-only
                ais_pkg::AIS_OFF_ASSIGN: begin
                    s_d.prdata[15:0] = i_assigned_functions;
                    s_d.prdata[ais_pkg::AIS_BIT_NONE] =
                        (i_assigned_functions == 16'h0000);
                end
                ais_pkg::AIS_OFF_STATUS: begin
                    s_d.prdata[ais_pkg::AIS_BIT_BIPOLAR] = bi_eff;
                    s_d.prdata[ais_pkg::AIS_BIT_BUSY] =
                        (s_q.fsm != ais_pkg::AIS_ST_IDLE);
                end
                ais_pkg::AIS_OFF_REF: s_d.prdata[15:0] = s_q.refv;
                ais_pkg::AIS_OFF_FILTD: s_d.prdata[15:0] = y;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (apb_acc & s_q.pready & i_pwrite & ~s_q.pslverr) begin
            case (i_paddr)
                // RULE_01: type select
                ais_pkg::AIS_OFF_CTRL: begin
                    s_d.cfg.type_cur = i_pwdata[ais_pkg::AIS_BIT_TYPE];
                    s_d.cfg.range_bi = i_pwdata[ais_pkg::AIS_BIT_RANGE];
                end
                ais_pkg::AIS_OFF_VMIN:
                    s_d.cfg.vmin = 7'(sat(i_pwdata, ais_pkg::AIS_LIM_V));
                ais_pkg::AIS_OFF_VMAX:
                    s_d.cfg.vmax = 7'(sat(i_pwdata, ais_pkg::AIS_LIM_V));
                ais_pkg::AIS_OFF_CMIN:
                    s_d.cfg.cmin = 8'(sat(i_pwdata, ais_pkg::AIS_LIM_C));
                ais_pkg::AIS_OFF_CMAX:
                    s_d.cfg.cmax = 8'(sat(i_pwdata, ais_pkg::AIS_LIM_C));
                // RULE_06: cutoff setting
                ais_pkg::AIS_OFF_FILT: begin
                    s_d.cfg.filt = 10'(sat(i_pwdata, ais_pkg::AIS_LIM_F));
                    s_d.recip_pend = 1'b1;
                end
                ais_pkg::AIS_OFF_XPT:
                    s_d.cfg.xpt = 7'(sat(i_pwdata, ais_pkg::AIS_LIM_P));
                ais_pkg::AIS_OFF_YPT:
                    s_d.cfg.ypt = 7'(sat(i_pwdata, ais_pkg::AIS_LIM_P));
                default: ;
            endcase
        end

        // -----------------------------------------------------------
        // sample capture and filter tick
        // -----------------------------------------------------------
        if (i_sample_valid) begin
            s_d.sample = i_sample;
        end
        if (s_q.tick_cnt >= 32'(P_TICK_CYCLES - 1)) begin
            s_d.tick_cnt = 32'h0000_0000;
            s_d.tick_pend = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
        end

        // shared restoring divider, one quotient bit per clock
        if (s_q.dv_cnt != 6'h00) begin
            s_d.dv_num = {s_q.dv_num[30:0], 1'b0};
            s_d.dv_rem = dstep[15:0];
            if (dstep >= {1'b0, s_q.dv_den}) begin
                s_d.dv_rem = 16'(dstep - {1'b0, s_q.dv_den});
                s_d.dv_num[0] = 1'b1;
            end
            s_d.dv_cnt = s_q.dv_cnt - 6'h01;
        end

        // -----------------------------------------------------------
        // conversion sequence
        // -----------------------------------------------------------
        case (s_q.fsm)
            ais_pkg::AIS_ST_IDLE: begin
                if (s_q.recip_pend) begin
                    // gain 2^24 / tau_ms, tick is 1 ms
                    s_d.recip_pend = apb_acc & s_q.pready & i_pwrite &
                                     (i_paddr == ais_pkg::AIS_OFF_FILT);
                    s_d.dv_num = ais_pkg::AIS_RECIP_ONE;
                    s_d.dv_den = 16'(s_q.cfg.filt * ais_pkg::AIS_FILT_MS);
                    s_d.dv_rem = 16'h0000;
                    s_d.dv_cnt = 6'h20;
                    if (s_q.cfg.filt == 10'h000) begin
                        s_d.dv_den = 16'h0001;
                    end
                    s_d.fsm = ais_pkg::AIS_ST_RECIP;
                end else if (s_q.tick_pend) begin
                    s_d.tick_pend = 1'b0;
                    // RULE_14: first-order low-pass
                    if (s_q.cfg.filt == 10'h000) begin
                        s_d.acc = {s_q.sample, 24'h00_0000};
                    end else begin
                        s_d.acc = s_q.acc + 40'(fprod);
                    end
                    s_d.fsm = ais_pkg::AIS_ST_PREP;
                end
            end
            ais_pkg::AIS_ST_RECIP: begin
                if (s_q.dv_cnt == 6'h00) begin
                    s_d.k = s_q.dv_num[24:0];
                    s_d.fsm = ais_pkg::AIS_ST_IDLE;
                end
            end
            ais_pkg::AIS_ST_PREP: begin
                // RULE_07: position within physical span
                s_d.fsm = ais_pkg::AIS_ST_SEGP;
                if (hi <= lo) begin
                    s_d.pos = (y >= hi) ? ais_pkg::AIS_FULL : 16'h0000;
                end else if (y <= lo) begin
                    s_d.pos = 16'h0000;
                end else if (y >= hi) begin
                    s_d.pos = ais_pkg::AIS_FULL;
                end else begin
                    s_d.dv_num = (y - lo) * ais_pkg::AIS_FULL;
                    s_d.dv_den = hi - lo;
                    s_d.dv_rem = 16'h0000;
                    s_d.dv_cnt = 6'h20;
                    s_d.fsm = ais_pkg::AIS_ST_POS;
                end
            end
            ais_pkg::AIS_ST_POS: begin
                if (s_q.dv_cnt == 6'h00) begin
                    s_d.pos = s_q.dv_num[15:0];
                    s_d.fsm = ais_pkg::AIS_ST_SEGP;
                end
            end
            ais_pkg::AIS_ST_SEGP: begin
                // RULE_13: pick segment
                s_d.dv_rem = 16'h0000;
                s_d.dv_cnt = 6'h20;
                s_d.fsm = ais_pkg::AIS_ST_SEG;
                if (s_q.pos > xi) begin
                    s_d.base = yi;
                    s_d.dv_num = (ais_pkg::AIS_FULL - yi) * (s_q.pos - xi);
                    s_d.dv_den = ais_pkg::AIS_FULL - xi;
                end else if (xi == 16'h0000) begin
                    // RULE_08: at X the output is Y
                    s_d.base = yi;
                    s_d.dv_num = 32'h0000_0000;
                    s_d.dv_cnt = 6'h00;
                end else begin
                    s_d.base = 16'h0000;
                    s_d.dv_num = yi * s_q.pos;
                    s_d.dv_den = xi;
                end
            end
            ais_pkg::AIS_ST_SEG: begin
                if (s_q.dv_cnt == 6'h00) begin
                    s_d.refv = sat({16'h0000, 16'(s_q.base +
                                   s_q.dv_num[15:0])}, ais_pkg::AIS_FULL);
                    // RULE_12: signed span when bidirectional
                    if (bi_eff) begin
                        s_d.refv = 16'({s_d.refv, 1'b0} -
                                       {1'b0, ais_pkg::AIS_FULL});
                    end
                    // RULE_11: otherwise 0..100 % as is
                    s_d.ref_valid = 1'b1;
                    s_d.fsm = ais_pkg::AIS_ST_IDLE;
                end
            end
            default: s_d.fsm = ais_pkg::AIS_ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q <= '0;
            s_q.cfg.vmin <= ais_pkg::AIS_RST_VMIN;
            s_q.cfg.vmax <= ais_pkg::AIS_RST_VMAX;
            s_q.cfg.cmin <= ais_pkg::AIS_RST_CMIN;
            s_q.cfg.cmax <= ais_pkg::AIS_RST_CMAX;
            s_q.cfg.filt <= ais_pkg::AIS_RST_FILT;
            s_q.cfg.xpt <= ais_pkg::AIS_RST_XPT;
            s_q.cfg.ypt <= ais_pkg::AIS_RST_YPT;
            s_q.fsm <= ais_pkg::AIS_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_prdata = s_q.prdata;
    assign o_pready = s_q.pready;
    assign o_pslverr = s_q.pslverr;
    assign o_reference = s_q.refv;
    assign o_reference_valid = s_q.ref_valid;
    assign o_bipolar_range_code = s_q.bipolar;
endmodule

`default_nettype wire

// >>> bench/ais_src_model.sv
/* converted sample source facing ais_scaler.
   assumes the bench sets the wanted level in mV or uA. */
`timescale 1ns/1ps
`default_nettype none
module ais_src_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // wanted level and sample out
    input wire logic [15:0] i_level,
    output logic [15:0] o_sample,
    output logic o_sample_valid
);
    logic [1:0] ph_q;
    // between strobes the bus toggles, so the stale value shows again on every other cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ph_q <= 2'h0;
            o_sample <= 16'h0000;
            o_sample_valid <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            o_sample_valid <= (ph_q == 2'h3);
            o_sample <= (ph_q == 2'h3) ? i_level : ~o_sample;
        end
    end
endmodule
`default_nettype wire

// >>> bench/ais_scaler_chk.sv
/* port checker for ais_scaler, bound below.
   assumes one clock and an active low reset. */
`timescale 1ns/1ps
`default_nettype none
module ais_scaler_chk #(
    parameter int P_TICK_CYCLES = 50
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // sample and reference
    input wire logic [15:0] i_sample,
    input wire logic i_sample_valid,
    input wire logic [15:0] i_assigned_functions,
    input wire logic [15:0] o_reference,
    input wire logic o_reference_valid,
    input wire logic o_bipolar_range_code
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_acc;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_ans;
        o_pready ##1 !o_pready;
    endsequence
    AST_APB_WAIT: assert property (s_acc |=> s_ans)
        else $error("pready not after one wait state");
    AST_APB_CAUSE: assert property
        ($rose(o_pready) |-> $past(i_psel && i_penable))
        else $error("pready without access");
    AST_UNMAPPED: assert property (o_pready && !i_pwrite
        && i_paddr > 12'h02c |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped read not refused");
    AST_MAPPED_OK: assert property (o_pready && i_paddr <= 12'h02c
        && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
        else $error("mapped access refused");
    AST_ASSIGN_RO: assert property (o_pready && !i_pwrite &&
        i_paddr == ais_pkg::AIS_OFF_ASSIGN |-> o_prdata == {15'h0,
        $past(i_assigned_functions) == 16'h0,
        $past(i_assigned_functions)})
        else $error("assignment view wrong");
    AST_VALID_PULSE: assert property
        (o_reference_valid |=> !o_reference_valid)
        else $error("reference valid longer than one cycle");
    AST_REF_HOLD: assert property
        ($changed(o_reference) |-> o_reference_valid)
        else $error("reference changed without valid");
    AST_REF_SPAN: assert property (o_reference_valid |->
        $signed(o_reference) <= 16'sd10000 &&
        $signed(o_reference) >= -16'sd10000)
        else $error("reference outside span");
    AST_UNI_POS: assert property (!o_bipolar_range_code[*8]
        ##0 o_reference_valid |-> !o_reference[15])
        else $error("negative reference in unidirectional range");
endmodule
bind ais_scaler ais_scaler_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) chk_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_sample(i_sample),
    .i_sample_valid(i_sample_valid),
    .i_assigned_functions(i_assigned_functions),
    .o_reference(o_reference), .o_reference_valid(o_reference_valid),
    .o_bipolar_range_code(o_bipolar_range_code));
`default_nettype wire

// >>> bench/ais_scaler_test.sv
/* self-checking bench for ais_scaler.
   assumes the sample source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module ais_scaler_test;
    localparam int TICK = 200;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, svalid, refv, bip, err;
    logic [15:0] sample, refo, level = 16'h0, afunc = 16'h0;
    int bad_count = 0, compares = 0, cyc = 0;
    always #25 clk = ~clk;
    ais_src_model src_u (.i_clk(clk), .i_rstn(rstn), .i_level(level),
        .o_sample(sample), .o_sample_valid(svalid));
    ais_scaler #(.P_TICK_CYCLES(TICK)) dut_u (.i_clk(clk),
        .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sample(sample), .i_sample_valid(svalid),
        .i_assigned_functions(afunc), .o_reference(refo),
        .o_reference_valid(refv), .o_bipolar_range_code(bip));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // no local limit: only the bench timeout ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd_is(input logic [11:0] a, input logic [31:0] e, string nm);
        apb(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task wait_ref(input int k);
        repeat (k) begin
            do begin
                @(posedge clk);
            end while (refv !== 1'b1);
        end
    endtask
    // the first pulse can still come from the old level; the second is always computed from the new one
    task ref_is(input logic [15:0] lv, input logic [15:0] e, string nm);
        @(posedge clk);
        level <= lv;
        wait_ref(2);
        chk(nm, {16'h0, e}, {16'h0, refo});
    endtask
    task reset_dut();
        @(posedge clk);
        rstn <= 0;
        repeat (8) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_defaults();
        logic [11:0] a[8];
        logic [31:0] e[8];
        a = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
            12'h018, 12'h01c};
        e = '{32'h0, 32'h0, 32'h0000_0064, 32'h0, 32'h0000_00c8, 32'h0,
            32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            rd_is(a[i], e[i], "reset value");
        end
    endtask
    task t_regs();
        apb(0, 12'h030, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1, ais_pkg::AIS_OFF_ASSIGN, 32'hffff_ffff);
        rd_is(ais_pkg::AIS_OFF_ASSIGN, 32'h0001_0000, "none");
        afunc <= 16'h00a5;
        rd_is(ais_pkg::AIS_OFF_ASSIGN, 32'h0000_00a5, "mask");
        apb(1, ais_pkg::AIS_OFF_VMAX, 32'h0000_00c8);
        rd_is(ais_pkg::AIS_OFF_VMAX, 32'h0000_0064, "vmax sat");
    endtask
    task t_voltage();
        ref_is(16'h1388, 16'h1388, "volt mid");
        rd_is(ais_pkg::AIS_OFF_FILTD, 32'h0000_1388, "filtered");
        apb(1, ais_pkg::AIS_OFF_VMIN, 32'h0000_0014);
        apb(1, ais_pkg::AIS_OFF_VMAX, 32'h0000_0050);
        ref_is(16'h1388, 16'h1388, "volt span");
        ref_is(16'h2328, 16'h2710, "clamp hi");
        ref_is(16'h03e8, 16'h0000, "clamp lo");
        apb(1, ais_pkg::AIS_OFF_VMIN, 32'h0);
        apb(1, ais_pkg::AIS_OFF_VMAX, 32'h0000_0064);
        apb(1, ais_pkg::AIS_OFF_XPT, 32'h0000_0032);
        apb(1, ais_pkg::AIS_OFF_YPT, 32'h0000_0014);
        ref_is(16'h09c4, 16'h03e8, "seg low");
        ref_is(16'h1388, 16'h07d0, "at x");
        ref_is(16'h1d4c, 16'h1770, "seg high");
        apb(1, ais_pkg::AIS_OFF_XPT, 32'h0);
        apb(1, ais_pkg::AIS_OFF_YPT, 32'h0);
    endtask
    task t_current();
        apb(1, ais_pkg::AIS_OFF_CTRL, 32'h0000_0003);
        apb(1, ais_pkg::AIS_OFF_CMIN, 32'h0000_0028);
        ref_is(16'h2ee0, 16'h0000, "bi mid");
        ref_is(16'h4e20, 16'h2710, "bi max");
        ref_is(16'h0fa0, 16'hd8f0, "bi min");
        chk("bipolar", 32'h1, {31'h0, bip});
        rd_is(ais_pkg::AIS_OFF_REF, 32'h0000_d8f0, "ref reg");
        rd_is(ais_pkg::AIS_OFF_STATUS, 32'h1, "status");
        apb(1, ais_pkg::AIS_OFF_CMIN, 32'h0000_0014);
        ref_is(16'h2ee0, 16'h15b3, "uni cur");
        chk("bipolar low min", 32'h0, {31'h0, bip});
        apb(1, ais_pkg::AIS_OFF_CTRL, 32'h0000_0002);
        ref_is(16'h1388, 16'h1388, "volt range");
        chk("bipolar volt", 32'h0, {31'h0, bip});
    endtask
    task t_filter();
        ref_is(16'h0000, 16'h0000, "filter base");
        apb(1, ais_pkg::AIS_OFF_FILT, 32'h0000_0001);
        wait_ref(1);
        @(posedge clk);
        level <= 16'h2710;
        wait_ref(1);
        chk("lp 1", 32'h1, 32'(refo > 900 && refo < 1100));
        wait_ref(1);
        chk("lp 2", 32'h1, 32'(refo > 1800 && refo < 2000));
        apb(1, ais_pkg::AIS_OFF_FILT, 32'h0000_07d0);
        rd_is(ais_pkg::AIS_OFF_FILT, 32'h0000_03e8, "filt sat");
    endtask
    // ----------------------------------------------------------------
    // run
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        reset_dut();
        t_defaults();
        t_regs();
        t_voltage();
        t_current();
        t_filter();
        reset_dut();
        t_defaults();
        close_out();
    end
endmodule
`default_nettype wire
